// file: logic/brtc_defs.svh
// brtc_defs.svh: offsets, field positions, reset values and counts of the
// bcd clock with user ram.
// assumes: included by its bare name from the package and design modules.
`ifndef BRTC_DEFS_SVH
`define BRTC_DEFS_SVH
`define BRTC_OFF_SEC    6'h00
`define BRTC_OFF_MIN    6'h01
`define BRTC_OFF_HOUR   6'h02
`define BRTC_OFF_WDAY   6'h03
`define BRTC_OFF_DATE   6'h04
`define BRTC_OFF_MON    6'h05
`define BRTC_OFF_YEAR   6'h06
`define BRTC_OFF_CTRL   6'h07
`define BRTC_RAM_BASE   6'h08
`define BRTC_RAM_DEPTH  56
`define BRTC_BIT_HALT   7
`define BRTC_BIT_H12    6
`define BRTC_BIT_PM     5
`define BRTC_BIT_OUT    7
`define BRTC_BIT_SQUARE_WAVE_ENABLE   4
`define BRTC_MASK_MIN   8'h7f
`define BRTC_MASK_HOUR  8'h7f
`define BRTC_MASK_WDAY  8'h07
`define BRTC_MASK_DATE  8'h3f
`define BRTC_MASK_MON   8'h1f
`define BRTC_MASK_CTRL  8'h93
`define BRTC_BUS_ADDR   7'h68
`define BRTC_XTAL_HZ    32768
`define BRTC_DIV_TOP    15'(`BRTC_XTAL_HZ - 1)
`define BRTC_RST_SEC    8'h80
`define BRTC_RST_ONE    8'h01
`define BRTC_RST_ZERO   8'h00
`define BRTC_PIN_IDLE   4'h3
`endif

// file: logic/brtc_pkg.sv
// brtc_pkg: types shared by the bcd clock core and its user ram.
// assumes: brtc_defs.svh is on the include path.
`include "brtc_defs.svh"
package brtc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX       = 3'b011,
    ST_RX_ACK   = 3'b100,
    ST_TX       = 3'b101,
    ST_TX_ACK   = 3'b110
  } brtc_state_t;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } brtc_ram_req_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] year;
  } brtc_time_t;
endpackage

// file: logic/brtc_ram.sv
// brtc_ram: the 56 general purpose bytes behind the clock registers.
// assumes: one port, write and read share the address; read data are
// registered and follow the address one clock later.
`timescale 1ns/10ps
`default_nettype none
`include "brtc_defs.svh"
module brtc_ram (
  input  wire logic                    clk,
  input  wire brtc_pkg::brtc_ram_req_t req,
  output var  logic [7:0]              rdata
);
  import brtc_pkg::*;

  logic [7:0] mem [0:`BRTC_RAM_DEPTH-1];

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[req.addr];
  end
endmodule
`default_nettype wire

// file: logic/brtc_core.sv
// brtc_core: bcd clock/calendar with user ram, two-wire serial slave and
// a square wave or fixed level output pin.
// assumes: crystal, two-wire and power-fail inputs are asynchronous pins;
// the two-wire data pin is open drain and resolved outside.
//
// Notes on behaviour
// - clock and control registers sit at locations 00h to 07h.
// - 56 free bytes sit at 08h to 3fh, any value.
// - location pointer rolls from 3fh back to 00h.
// - time and calendar held as packed bcd, tens high, units low.
// - seconds, minutes, date, month, year wrap and carry onward.
// - date wraps at true month end, leap february included.
// - weekday steps 01 to 07 once at midnight.
// - seconds bit 7 set halts the oscillator and counting.
// - hours bit 6 picks 12-hour with half-day flag, else 24-hour.
// - 12-hour mode counts 1-12, bit 5 is pm, flips at 11 to 12.
// - 24-hour mode uses bit 5 as second tens-of-hours bit.
// - control at 07h: out bit 7, enable bit 4, rate 1:0.
// - enable low: pin shows the out bit as a static level.
// - enable high: pin toggles at 1 hz, 4.096 khz, 8.192 khz or 32.768 khz.
// - power fail aborts any transfer and clears the pointer.
// - bus traffic ignored while power fail stays asserted.
// - answer only target address 1101000 plus direction bit.
// - first written byte loads pointer; pointer steps per data byte.
// - read without pointer write starts at the held pointer.
`timescale 1ns/10ps
`default_nettype none
`include "brtc_defs.svh"
module brtc_core (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  input  wire logic crystal_input,
  input  wire logic power_fail,
  output var  logic wave_output_pin
);
  import brtc_pkg::*;

  // --------------------------------------------------------------------
  // calendar helpers
  // --------------------------------------------------------------------
  // bcd step: wraps hi to lo with carry in bit 8
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v == hi) begin
      return {1'b1, lo};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction

  // last date of a bcd month; year counts 00-99, every fourth is leap
  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      return leap ? 8'h29 : 8'h28;
    end
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  // bit 0 clock line, 1 data line, 2 crystal, 3 power fail
  logic [3:0]    pin_s1;
  logic [3:0]    pin_s2;
  logic [3:0]    pin_s3;
  logic [3:0]    pin_lvl;
  logic [3:0]    pin_prev;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;
  logic          xtal_rise;
  logic          pf;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1 <= `BRTC_PIN_IDLE;
      pin_s2 <= `BRTC_PIN_IDLE;
      pin_s3 <= `BRTC_PIN_IDLE;
    end else begin
      pin_s1 <= {power_fail, crystal_input, sda_in, scl_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // a level moves only once the last two stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_lvl  <= `BRTC_PIN_IDLE;
      pin_prev <= `BRTC_PIN_IDLE;
    end else begin
      pin_lvl  <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
      pin_prev <= pin_lvl;
    end
  end

  assign scl_rise  = pin_lvl[0] & ~pin_prev[0];
  assign scl_fall  = ~pin_lvl[0] & pin_prev[0];
  assign bus_start = pin_lvl[0] & pin_prev[0] & pin_prev[1] & ~pin_lvl[1];
  assign bus_stop  = pin_lvl[0] & pin_prev[0] & ~pin_prev[1] & pin_lvl[1];
  assign xtal_rise = pin_lvl[2] & ~pin_prev[2];
  assign pf        = pin_lvl[3];

  // --------------------------------------------------------------------
  // registers and read path
  // --------------------------------------------------------------------
  brtc_time_t    tm;
  brtc_time_t    next_tm;
  brtc_time_t    snap;
  logic [7:0]    ctrl;
  logic          halt;
  logic          host_we;
  logic [5:0]    host_addr;
  logic [7:0]    host_wdata;
  logic          time_wr;
  logic [5:0]    ptr;
  logic [7:0]    rd_byte;
  logic [7:0]    ram_rdata;
  brtc_ram_req_t ram_req;

  assign halt    = tm.sec[`BRTC_BIT_HALT];
  assign time_wr = host_we && (host_addr < `BRTC_OFF_CTRL);

  // ram index is location minus base; the write address wins the port
  assign ram_req.we    = host_we && (host_addr >= `BRTC_RAM_BASE);
  assign ram_req.addr  = host_we ? host_addr - `BRTC_RAM_BASE
                                 : ptr - `BRTC_RAM_BASE;
  assign ram_req.wdata = host_wdata;

  brtc_ram u_ram (
    .clk   (clk),
    .req   (ram_req),
    .rdata (ram_rdata)
  );

  // time fields come from the snapshot so a burst never tears
  always_comb begin
    unique case (ptr)
      `BRTC_OFF_SEC:  rd_byte = snap.sec;
      `BRTC_OFF_MIN:  rd_byte = snap.min;
      `BRTC_OFF_HOUR: rd_byte = snap.hour;
      `BRTC_OFF_WDAY: rd_byte = snap.wday;
      `BRTC_OFF_DATE: rd_byte = snap.date;
      `BRTC_OFF_MON:  rd_byte = snap.mon;
      `BRTC_OFF_YEAR: rd_byte = snap.year;
      `BRTC_OFF_CTRL: rd_byte = ctrl;
      default:        rd_byte = ram_rdata;
    endcase
  end

  // --------------------------------------------------------------------
  // two-wire slave
  // --------------------------------------------------------------------
  brtc_state_t   state;
  logic [3:0]    cnt;
  logic [7:0]    shift;
  logic [7:0]    tx_shift;
  logic          rw;
  logic          first;
  logic          nack;

  always_ff @(posedge clk) begin
    host_we <= 1'b0;
    if (rst) begin
      state      <= ST_IDLE;
      ptr        <= 6'h00;
      cnt        <= 4'h0;
      shift      <= 8'h00;
      tx_shift   <= 8'h00;
      rw         <= 1'b0;
      first      <= 1'b0;
      nack       <= 1'b0;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
      host_addr  <= 6'h00;
      host_wdata <= 8'h00;
      snap       <= '0;
    end else if (pf) begin
      state  <= ST_IDLE;
      ptr    <= 6'h00;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      // a repeated start also lands here and takes a fresh snapshot
      state  <= ST_ADDR;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
      snap   <= tm;
    end else if (bus_stop) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        ST_ADDR, ST_RX: begin
          shift <= {shift[6:0], pin_lvl[1]};
          cnt   <= cnt + 4'h1;
        end
        ST_TX_ACK: begin
          nack <= pin_lvl[1];
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        ST_ADDR: begin
          if (cnt == 4'h8) begin
            if (shift[7:1] == `BRTC_BUS_ADDR) begin
              state  <= ST_ADDR_ACK;
              rw     <= shift[0];
              sda_oe <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (rw) begin
            tx_shift <= {rd_byte[6:0], 1'b0};
            sda_oe   <= ~rd_byte[7];
            ptr      <= ptr + 6'h01;
            cnt      <= 4'h1;
            state    <= ST_TX;
          end else begin
            sda_oe <= 1'b0;
            first  <= 1'b1;
            cnt    <= 4'h0;
            state  <= ST_RX;
          end
        end
        ST_RX: begin
          if (cnt == 4'h8) begin
            if (first) begin
              ptr <= shift[5:0];
            end else begin
              host_we    <= 1'b1;
              host_addr  <= ptr;
              host_wdata <= shift;
              ptr        <= ptr + 6'h01;
            end
            sda_oe <= 1'b1;
            state  <= ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          sda_oe <= 1'b0;
          first  <= 1'b0;
          cnt    <= 4'h0;
          state  <= ST_RX;
        end
        ST_TX: begin
          if (cnt == 4'h8) begin
            sda_oe <= 1'b0;
            state  <= ST_TX_ACK;
          end else begin
            sda_oe   <= ~tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
            cnt      <= cnt + 4'h1;
          end
        end
        ST_TX_ACK: begin
          if (nack) begin
            state <= ST_IDLE;
          end else begin
            tx_shift <= {rd_byte[6:0], 1'b0};
            sda_oe   <= ~rd_byte[7];
            ptr      <= ptr + 6'h01;
            cnt      <= 4'h1;
            state    <= ST_TX;
          end
        end
        ST_IDLE: begin
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // timebase
  // --------------------------------------------------------------------
  logic [14:0]   div;
  logic          tick;

  // a halted oscillator gives no edges, so the divider freezes too
  assign tick = xtal_rise && !halt && !time_wr
                && (div == `BRTC_DIV_TOP);

  always_ff @(posedge clk) begin
    if (rst) begin
      div <= 15'h0000;
    end else if (time_wr) begin
      div <= 15'h0000;
    end else if (xtal_rise && !halt) begin
      div <= div + 15'h0001;
    end
  end

  // --------------------------------------------------------------------
  // calendar cascade
  // --------------------------------------------------------------------
  logic [8:0]    step_sec;
  logic [8:0]    step_min;
  logic [8:0]    step_h24;
  logic [8:0]    step_h12;
  logic [8:0]    step_wday;
  logic [8:0]    step_date;
  logic [8:0]    step_mon;
  logic [8:0]    step_year;
  logic          c_min;
  logic          c_hour;
  logic          c_day;
  logic          c_mon;
  logic          c_year;
  logic          pm;

  assign pm        = tm.hour[`BRTC_BIT_PM];
  assign step_sec  = bcd_step({1'b0, tm.sec[6:0]}, 8'h00, 8'h59);
  assign step_min  = bcd_step(tm.min, 8'h00, 8'h59);
  assign step_h24  = bcd_step({2'b00, tm.hour[5:0]}, 8'h00, 8'h23);
  assign step_h12  = bcd_step({3'b000, tm.hour[4:0]}, 8'h01, 8'h12);
  assign step_wday = bcd_step(tm.wday, 8'h01, 8'h07);
  assign step_date = bcd_step(tm.date, 8'h01,
                              last_day(tm.mon, tm.year));
  assign step_mon  = bcd_step(tm.mon, 8'h01, 8'h12);
  assign step_year = bcd_step(tm.year, 8'h00, 8'h99);

  always_comb begin
    next_tm = tm;
    c_min   = tick && step_sec[8];
    c_hour  = c_min && step_min[8];
    c_day   = 1'b0;
    if (tick) begin
      next_tm.sec = {tm.sec[7], step_sec[6:0]};
    end
    if (c_min) begin
      next_tm.min = step_min[7:0];
    end
    if (c_hour) begin
      if (tm.hour[`BRTC_BIT_H12]) begin
        if (tm.hour[4:0] == 5'h11) begin
          next_tm.hour = {2'b01, ~pm, 5'h12};
          c_day        = pm;
        end else begin
          next_tm.hour = {2'b01, pm, step_h12[4:0]};
        end
      end else begin
        next_tm.hour = {2'b00, step_h24[5:0]};
        c_day        = step_h24[8];
      end
    end
    c_mon  = c_day && step_date[8];
    c_year = c_mon && step_mon[8];
    if (c_day) begin
      next_tm.wday = step_wday[7:0];
      next_tm.date = step_date[7:0];
    end
    if (c_mon) begin
      next_tm.mon = step_mon[7:0];
    end
    if (c_year) begin
      next_tm.year = step_year[7:0];
    end
  end

  // host writes land whole; reserved bits are dropped on the way in
  always_ff @(posedge clk) begin
    if (rst) begin
      tm.sec  <= `BRTC_RST_SEC;
      tm.min  <= `BRTC_RST_ZERO;
      tm.hour <= `BRTC_RST_ZERO;
      tm.wday <= `BRTC_RST_ONE;
      tm.date <= `BRTC_RST_ONE;
      tm.mon  <= `BRTC_RST_ONE;
      tm.year <= `BRTC_RST_ZERO;
    end else if (time_wr) begin
      case (host_addr)
        `BRTC_OFF_SEC:  tm.sec  <= host_wdata;
        `BRTC_OFF_MIN:  tm.min  <= host_wdata & `BRTC_MASK_MIN;
        `BRTC_OFF_HOUR: tm.hour <= host_wdata & `BRTC_MASK_HOUR;
        `BRTC_OFF_WDAY: tm.wday <= host_wdata & `BRTC_MASK_WDAY;
        `BRTC_OFF_DATE: tm.date <= host_wdata & `BRTC_MASK_DATE;
        `BRTC_OFF_MON:  tm.mon  <= host_wdata & `BRTC_MASK_MON;
        default:        tm.year <= host_wdata;
      endcase
    end else begin
      tm <= next_tm;
    end
  end

  // --------------------------------------------------------------------
  // control register and output pin
  // --------------------------------------------------------------------
  logic          wave;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `BRTC_RST_ZERO;
    end else if (host_we && host_addr == `BRTC_OFF_CTRL) begin
      ctrl <= host_wdata & `BRTC_MASK_CTRL;
    end
  end

  // divider bit k runs at 32768 / 2^(k+1) hz
  always_comb begin
    unique case (ctrl[1:0])
      2'b00:   wave = div[14];
      2'b01:   wave = div[2];
      2'b10:   wave = div[1];
      // a halted oscillator has no edges to pass on, so the pin stays low
      default: wave = pin_lvl[2] & ~halt;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wave_output_pin <= 1'b0;
    end else if (ctrl[`BRTC_BIT_SQUARE_WAVE_ENABLE]) begin
      wave_output_pin <= wave;
    end else begin
      wave_output_pin <= ctrl[`BRTC_BIT_OUT];
    end
  end
endmodule
`default_nettype wire

// file: tb/brtc_core_sva.sv
// brtc_core_sva: port-level checks of the bcd clock core.
// assumes: bound to brtc_core; the data line is resolved in the bench.
`timescale 1ns/10ps
`default_nettype none
module brtc_core_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic crystal_input,
  input wire logic power_fail,
  input wire logic wave_output_pin
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [4:0] quiet;

  // cycles with crystal and bus frozen; pin must then hold still
  always_ff @(posedge clk) begin
    if (rst) begin
      quiet <= 5'h00;
    end else if ($changed(crystal_input) || $changed(scl_in)
                 || $changed(sda_in)) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h1f) begin
      quiet <= quiet + 5'h01;
    end
  end

  a_rst_idle: assert property (disable iff (1'b0)
    rst |=> !sda_oe && !wave_output_pin)
    else $error("outputs not idle after reset");
  a_drive_low: assert property (sda_out == 1'b0)
    else $error("data drive value not zero");
  a_start_quiet: assert property (
    scl_in && $fell(sda_in) |-> !sda_oe [*8])
    else $error("data pulled during start");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
  a_pf_abort: assert property (
    $rose(power_fail) |-> ##[1:8] !sda_oe)
    else $error("transfer not aborted on power fail");
  a_pf_silent: assert property (power_fail [*8] |-> !sda_oe)
    else $error("bus answered during power fail");
  a_pin_quiet: assert property (
    quiet >= 5'd16 |-> $stable(wave_output_pin))
    else $error("pin moved without crystal or bus");

  c_ack: cover property ($rose(sda_oe));
  c_pin: cover property ($changed(wave_output_pin));
  c_pf: cover property ($rose(power_fail));
endmodule

bind brtc_core brtc_core_sva u_sva (
  .clk             (clk),
  .rst             (rst),
  .scl_in          (scl_in),
  .sda_in          (sda_in),
  .sda_out         (sda_out),
  .sda_oe          (sda_oe),
  .crystal_input   (crystal_input),
  .power_fail      (power_fail),
  .wave_output_pin (wave_output_pin)
);
`default_nettype wire

// file: tb/brtc_master.sv
// brtc_master: two-wire bus master model facing the clock core.
// assumes: data line open drain with pull-up, resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
module brtc_master #(
  parameter int HALF = 16
) (
  input  wire logic clk,
  output var  logic scl,
  output var  logic sda_drv,
  input  wire logic sda_wire
);
  // ----------------------------------------------------------------
  // bus conditions and bits
  // ----------------------------------------------------------------
  // clock stands high between frames; released data reads as pull-up
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic start();
    repeat (HALF) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (HALF) @(posedge clk);
    scl <= 1'b0;
  endtask

  task automatic stop();
    repeat (HALF / 2) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (HALF / 2) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (2 * HALF) @(posedge clk);
  endtask

  // data changes mid-low, sampled late in the high phase
  task automatic bitx(input logic v, output logic r);
    repeat (HALF / 2) @(posedge clk);
    sda_drv <= v;
    repeat (HALF / 2) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF - 1) @(posedge clk);
    #1 r = sda_wire;
    @(posedge clk);
    scl <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ackbit,
                      output logic [7:0] rx, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], b);
      rx[i] = b;
    end
    bitx(ackbit, ack);
  endtask
endmodule
`default_nettype wire

// file: tb/brtc_core_tb.sv
// brtc_core_tb: register, pin and power-fail tests of the clock core.
// assumes: bus master model and bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module brtc_core_tb;
  import brtc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and checks
  // ----------------------------------------------------------------
  logic       clk;
  logic       rst;
  logic       scl;
  logic       sda_drv;
  logic       sda_oe;
  logic       sda_wire;
  logic       xtal = 1'b0;
  logic       xtal_run;
  logic       pf;
  logic       pin;
  logic [2:0] xdiv = 3'h0;
  logic [7:0] rx;
  logic       ack;
  logic [7:0] wq [$];
  logic [7:0] eq [$];
  logic [7:0] rates [3] = '{8'h11, 8'h12, 8'h13};
  int         exp_n [3] = '{16, 32, 128};
  int         n;
  int         fails = 0;
  int         tests_run = 0;
  int         cycles = 0;

  assign sda_wire = sda_oe ? 1'b0 : sda_drv;

  brtc_master m (.clk(clk), .scl(scl), .sda_drv(sda_drv),
                 .sda_wire(sda_wire));
  brtc_core DUT (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
                 .sda_out(), .sda_oe(sda_oe), .crystal_input(xtal),
                 .power_fail(pf), .wave_output_pin(pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // crystal stand-in, 8 clk per half period, far faster than real
  always @(posedge clk) begin
    xdiv <= xdiv + 3'h1;
    if (xtal_run && xdiv == 3'h7) xtal <= ~xtal;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      $display("Error t=%0t run limit reached", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      fails++;
      $display("Error t=%0t edges %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] p);
    m.start();
    m.xfer(8'hd0, 1'b1, rx, ack);
    m.xfer(p, 1'b1, rx, ack);
    foreach (wq[i]) m.xfer(wq[i], 1'b1, rx, ack);
    m.stop();
  endtask

  // optional pointer write, then a read of eq.size() bytes
  task automatic rd_cmp(input logic setp, input logic [7:0] p);
    if (setp) begin
      m.start();
      m.xfer(8'hd0, 1'b1, rx, ack);
      m.xfer(p, 1'b1, rx, ack);
      m.stop();
    end
    m.start();
    m.xfer(8'hd1, 1'b1, rx, ack);
    foreach (eq[i]) begin
      m.xfer(8'hff, i == eq.size() - 1, rx, ack);
      chk8(rx, eq[i]);
    end
    m.stop();
  endtask

  task automatic edges(input int cyc, output int cnt);
    logic prev;
    cnt = 0;
    repeat (32) @(negedge clk);
    prev = pin;
    repeat (cyc) begin
      @(negedge clk);
      if (pin !== prev) cnt++;
      prev = pin;
    end
  endtask

  initial begin
    rst = 1'b1;
    pf = 1'b0;
    xtal_run = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    eq = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    rd_cmp(1'b1, 8'h00);
    wq = '{8'ha5, 8'h5a, 8'h85, 8'h37, 8'h52};
    wr(8'h3e);
    eq = wq;
    rd_cmp(1'b1, 8'h3e);
    eq = '{8'h01};
    rd_cmp(1'b0, 8'h00);
    wq = '{8'hff};
    wr(8'h07);
    eq = '{8'h93};
    rd_cmp(1'b1, 8'h07);
    edges(1024, n);
    chk_rng(n, 0, 0);
    wq = '{8'h00};
    wr(8'h00);
    for (int i = 0; i < 3; i++) begin
      wq = '{rates[i]};
      wr(8'h07);
      edges(1024, n);
      chk_rng(n, exp_n[i] - 1, exp_n[i] + 1);
    end
    for (int i = 0; i < 2; i++) begin
      wq = '{{~i[0], 7'h00}};
      wr(8'h07);
      repeat (16) @(negedge clk);
      chk8({7'h00, pin}, {7'h00, ~i[0]});
    end
    m.start();
    m.xfer(8'ha0, 1'b1, rx, ack);
    m.stop();
    chk8({7'h00, ack}, 8'h01);
    wq = '{8'h22};
    wr(8'h20);
    pf <= 1'b1;
    repeat (8) @(posedge clk);
    m.start();
    m.xfer(8'hd0, 1'b1, rx, ack);
    chk8({7'h00, ack}, 8'h01);
    m.xfer(8'h20, 1'b1, rx, ack);
    m.xfer(8'h11, 1'b1, rx, ack);
    m.stop();
    pf <= 1'b0;
    repeat (8) @(posedge clk);
    eq = '{8'h00};
    rd_cmp(1'b0, 8'h00);
    eq = '{8'h22};
    rd_cmp(1'b1, 8'h20);
    xtal_run <= 1'b0;
    repeat (64) @(posedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
